// *** hw/adc_parallel_host_port.sv ***
// Purpose: strobe-driven parallel host port of a dual-input converter
// Assumes: pins pass two flip-flops; conversion words arrive on clk
// Notes: strobes are rebuilt on clk, so edges are seen two clk cycles late
`include "host_port_regs.svh"
module adc_parallel_host_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic select_low_input_b,
  input wire logic select_high_input,
  input wire logic read_b,
  input wire logic write_b,
  input wire logic reg_addr,
  input wire logic [`HP_DATA_W-1:0] data_in,
  output logic [`HP_DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic conversion_clock,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [`HP_DATA_W-1:0] sample_data,
  output logic sample_ready_flag,
  output logic [`HP_DATA_W-1:0] ctrl0,
  output logic [`HP_DATA_W-1:0] ctrl1
);
  localparam int SYNC_W = 5 + `HP_DATA_W;
  localparam int DROP_CYC = `HP_READY_DROP_CYC;
  logic [SYNC_W-1:0] pin_async;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic cs_low_b_s;
  logic cs_high_s;
  logic rd_b_s;
  logic wr_b_s;
  logic addr_s;
  logic [`HP_DATA_W-1:0] bus_s;
  logic selected;
  logic combined;
  logic rd_act;
  logic wr_act;
  host_port_pkg::access_t acc_next;
  host_port_pkg::access_t acc_reg;
  logic fifo_valid;
  logic [`HP_DATA_W-1:0] fifo_data;
  logic pop;
  logic [`HP_DATA_W-1:0] ctrl0_reg;
  logic [`HP_DATA_W-1:0] ctrl1_reg;
  logic [`HP_DATA_W-1:0] dout_reg;
  logic flag_reg;

  // conversion_clock only matters to host timing; kept as a visible pin
  assign pin_async = {select_low_input_b, select_high_input, read_b,
                      write_b, reg_addr, data_in};

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg <= {2'b10, 2'b11, 1'b0, {`HP_DATA_W{1'b0}}};
      sync2_reg <= {2'b10, 2'b11, 1'b0, {`HP_DATA_W{1'b0}}};
    end
    else
    begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
    end
  end

  assign {cs_low_b_s, cs_high_s, rd_b_s, wr_b_s, addr_s, bus_s} = sync2_reg;

  assign selected = !cs_low_b_s && cs_high_s;
  assign combined = ctrl1_reg[`HP_COMBINED_BIT];

  always_comb
  begin
    if (combined)
    begin
      // read input ignored; direction high reads, low writes
      rd_act = wr_b_s;
      wr_act = !wr_b_s;
    end
    else
    begin
      rd_act = !rd_b_s && wr_b_s;
      wr_act = !wr_b_s && rd_b_s;
    end
  end

  always_comb
  begin
    acc_next = host_port_pkg::ACC_IDLE;
    if (selected && rd_act)
    begin
      acc_next = host_port_pkg::ACC_READ;
    end
    else if (selected && wr_act)
    begin
      acc_next = host_port_pkg::ACC_WRITE;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_reg <= host_port_pkg::ACC_IDLE;
    end
    else
    begin
      acc_reg <= acc_next;
    end
  end

  // one word leaves the buffer at the start of each read strobe
  assign pop = (acc_next == host_port_pkg::ACC_READ) &&
               (acc_reg != host_port_pkg::ACC_READ) && fifo_valid;

  sample_fifo #(
    .WIDTH(`HP_DATA_W),
    .DEPTH(`HP_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dout_reg <= '0;
    end
    else if (pop)
    begin
      dout_reg <= fifo_data;
    end
  end

  assign data_out = dout_reg;
  assign data_oe = (acc_reg == host_port_pkg::ACC_READ);

  // flag follows buffer occupancy but drops as soon as a read begins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flag_reg <= 1'b0;
    end
    else if (acc_next == host_port_pkg::ACC_READ)
    begin
      flag_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= fifo_valid;
    end
  end

  assign sample_ready_flag = flag_reg;

  // registers reload on every cycle of the write strobe; last word wins,
  // so a word still settling through the synchronisers is overwritten
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl0_reg <= `HP_CTRL0_RESET;
      ctrl1_reg <= `HP_CTRL1_RESET;
    end
    else if (acc_next == host_port_pkg::ACC_WRITE)
    begin
      if (addr_s == `HP_CTRL0_ADDR)
      begin
        ctrl0_reg <= bus_s;
      end
      else
      begin
        ctrl1_reg <= bus_s;
      end
    end
  end

  assign ctrl0 = ctrl0_reg;
  assign ctrl1 = ctrl1_reg;

  property p_read_oe;
    @(posedge clk) disable iff (!rst_b)
    (selected && rd_act) |=> data_oe;
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("read strobe missing");

  property p_read_drop;
    @(posedge clk) disable iff (!rst_b)
    !selected |=> !data_oe;
  endproperty
  a_read_drop: assert property (p_read_drop)
    else $error("read strobe not removed");

  property p_oe_only_read;
    @(posedge clk) disable iff (!rst_b)
    data_oe |-> $past(!cs_low_b_s && cs_high_s &&
                      (combined ? wr_b_s : (!rd_b_s && wr_b_s)));
  endproperty
  a_oe_only_read: assert property (p_oe_only_read)
    else $error("bus driven without read");

  property p_write_load;
    @(posedge clk) disable iff (!rst_b)
    (selected && wr_act && addr_s) |=> ctrl1_reg == $past(bus_s);
  endproperty
  a_write_load: assert property (p_write_load)
    else $error("control 1 not loaded");

  property p_write_end;
    @(posedge clk) disable iff (!rst_b)
    !selected |=> $stable(ctrl0_reg) && $stable(ctrl1_reg);
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("write without strobe");

  property p_both_none;
    @(posedge clk) disable iff (!rst_b)
    (!combined && !rd_b_s && !wr_b_s) |=> !data_oe && $stable(ctrl1_reg);
  endproperty
  a_both_none: assert property (p_both_none)
    else $error("strobe with both inputs active");

  property p_flag_drop;
    @(posedge clk) disable iff (!rst_b)
    (selected && rd_act) |-> ##[1:DROP_CYC] !sample_ready_flag;
  endproperty
  a_flag_drop: assert property (p_flag_drop)
    else $error("ready flag not withdrawn");

  property p_combined_read;
    @(posedge clk) disable iff (!rst_b)
    (combined && selected && wr_b_s) |=> data_oe;
  endproperty
  a_combined_read: assert property (p_combined_read)
    else $error("direction high did not read");
endmodule

// *** hw/host_port_pkg.sv ***
// Purpose: types of the parallel host port
// Assumes: constants come from host_port_regs.svh
// Notes: none
package host_port_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } access_t;
endpackage

// *** hw/host_port_regs.svh ***
// Purpose: constants of the parallel host port
// Assumes: 50 MHz clk, 10-bit conversion words
// Notes: timing counts are ns figures divided by HP_CLK_NS, at least one
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
`define HP_DATA_W 10
`define HP_FIFO_DEPTH 16
`define HP_CLK_NS 20
`define HP_CTRL0_ADDR 1'h0
`define HP_CTRL1_ADDR 1'h1
`define HP_CTRL0_RESET 10'h000
`define HP_CTRL1_RESET 10'h030
`define HP_COMBINED_BIT 6
`define HP_READY_DROP_NS 12
`define HP_READY_DROP_CYC \
  (((`HP_READY_DROP_NS / `HP_CLK_NS) < 1) ? 1 : \
   (`HP_READY_DROP_NS / `HP_CLK_NS))
`endif

// *** hw/sample_fifo.sv ***
// Purpose: word buffer between conversion pipeline and host reads
// Assumes: single clock, valid/ready both sides
// Notes: full and empty derived from an occupancy count
module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// *** test/host_master.sv ***
// Purpose: host bus master model for the parallel port pins
// Assumes: pins change just after clk rises and hold until stop
// Notes: bus word is inverted once released, so no stale word passes
module host_master (
  input wire logic clk,
  input wire logic conversion_clock,
  output logic select_low_input_b,
  output logic select_high_input,
  output logic read_b,
  output logic write_b,
  output logic reg_addr,
  output logic [9:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    select_low_input_b = 1'h1;
    select_high_input = 1'h0;
    read_b = 1'h1;
    write_b = 1'h1;
    reg_addr = 1'h0;
    data_in = 10'h155;
  end
  task start(input logic rb, wb, hi, a, input logic [9:0] d,
             input logic align);
    if (align)
      @(negedge conversion_clock);
    @(posedge clk);
    select_low_input_b <= 1'h0;
    select_high_input <= hi;
    read_b <= rb;
    write_b <= wb;
    reg_addr <= a;
    data_in <= d;
  endtask
  task stop;
    @(posedge clk);
    select_low_input_b <= 1'h1;
    select_high_input <= 1'h0;
    read_b <= 1'h1;
    write_b <= 1'h1;
    data_in <= ~data_in;
    // idle gap so the next access counts as new
    repeat (4) @(posedge clk);
  endtask
endmodule

// *** test/tb_adc_parallel_host_port.sv ***
// Purpose: self-checking bench of the parallel host port
// Assumes: two-edge pin latency through the two-flop synchronisers
// Notes: conversion clock runs at one eighth of clk
`include "host_port_regs.svh"
module tb_adc_parallel_host_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic conversion_clock = 1'h0;
  logic sample_valid = 1'h0;
  logic [`HP_DATA_W-1:0] sample_data = 10'h000;
  logic [`HP_DATA_W-1:0] data_in, data_out, ctrl0, ctrl1;
  logic sel_b, sel_hi, read_b, write_b, reg_addr;
  logic data_oe, sample_ready, sample_ready_flag;
  logic [2:0] cc_cnt = 3'h0;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cc_cnt <= cc_cnt + 3'h1;
    conversion_clock <= cc_cnt[2];
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  host_master i_host (.clk(clk), .conversion_clock(conversion_clock),
    .select_low_input_b(sel_b), .select_high_input(sel_hi),
    .read_b(read_b), .write_b(write_b), .reg_addr(reg_addr),
    .data_in(data_in));
  adc_parallel_host_port i_dut (.clk(clk), .rst_b(rst_b),
    .select_low_input_b(sel_b), .select_high_input(sel_hi),
    .read_b(read_b), .write_b(write_b), .reg_addr(reg_addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .conversion_clock(conversion_clock), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data),
    .sample_ready_flag(sample_ready_flag), .ctrl0(ctrl0), .ctrl1(ctrl1));
  task chk(input string what, input logic [9:0] exp, got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wait_oe(input logic v);
    for (int i = 0; i < 8 && data_oe !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("data_oe", {9'h0, v}, {9'h0, data_oe});
  endtask
  task wr(input logic a, input logic [9:0] d);
    i_host.start(1'h1, 1'h0, 1'h1, a, d, 1'h0);
    repeat (4) @(posedge clk);
    i_host.stop();
    #1;
  endtask
  // combined read keeps the read input high and is timed by select
  task rd(input logic [9:0] exp, input logic cmb);
    i_host.start(cmb, 1'h1, 1'h1, 1'h0, 10'h000, cmb);
    wait_oe(1'h1);
    chk("data_out", exp, data_out);
    chk("flag", 10'h0, {9'h0, sample_ready_flag});
    i_host.stop();
    wait_oe(1'h0);
  endtask
  task t_reset;
    chk("ctrl0", `HP_CTRL0_RESET, ctrl0);
    chk("ctrl1", `HP_CTRL1_RESET, ctrl1);
    chk("data_oe", 10'h0, {9'h0, data_oe});
    chk("sample_ready", 10'h1, {9'h0, sample_ready});
  endtask
  task t_write;
    wr(1'h0, 10'h2a5);
    wr(1'h1, 10'h03c);
    chk("ctrl0", 10'h2a5, ctrl0);
    chk("ctrl1", 10'h03c, ctrl1);
  endtask
  // fill until the buffer refuses a seventeenth word
  task t_fill;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      sample_valid <= 1'h1;
      sample_data <= 10'h300 + 10'(i);
    end
    @(posedge clk);
    sample_data <= 10'h0ff;
    repeat (2) @(posedge clk);
    #1;
    chk("sample_ready", 10'h0, {9'h0, sample_ready});
    @(posedge clk);
    sample_valid <= 1'h0;
    sample_data <= 10'h300;
    chk("flag", 10'h1, {9'h0, sample_ready_flag});
  endtask
  task t_refuse;
    i_host.start(1'h0, 1'h0, 1'h1, 1'h0, 10'h3ff, 1'h0);
    repeat (6) @(posedge clk);
    #1;
    chk("data_oe", 10'h0, {9'h0, data_oe});
    chk("ctrl0", 10'h2a5, ctrl0);
    i_host.stop();
    i_host.start(1'h0, 1'h1, 1'h0, 1'h0, 10'h3ff, 1'h0);
    repeat (6) @(posedge clk);
    #1;
    chk("data_oe", 10'h0, {9'h0, data_oe});
    i_host.stop();
  endtask
  task t_drain;
    for (int i = 0; i < 8; i++)
      rd(10'h300 + 10'(i), 1'h0);
    wr(1'h1, 10'h070);
    chk("ctrl1", 10'h070, ctrl1);
    for (int i = 8; i < 16; i++)
      rd(10'h300 + 10'(i), 1'h1);
    wr(1'h0, 10'h111);
    chk("ctrl0", 10'h111, ctrl0);
    chk("flag", 10'h0, {9'h0, sample_ready_flag});
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    #1;
    t_reset();
    t_write();
    t_fill();
    t_refuse();
    t_drain();
    wrap_up();
  end
endmodule
